// >>> hdl/sync_tx_params.svh
// Constants of the synchronous master transmitter
// Summary of operation
// - Two lines, data and clock, half-duplex.
// - No start or stop bits sent.
// - Clocked-mode bit selects synchronous operation.
// - Clock-source bit makes device shift-clock master.
// - Either receive enable set means receive mode.
// - Port enable clear makes port inactive.
// - Master drives clock pin, driver auto-enabled.
// - Data changes leading edge, sampled trailing.
// - Exactly one clock per data bit.
// - Transmit enables data driver; clock driver on in master mode.
// - Holding write starts; waits for shifter.
// - Empty shifter loads at once, shifting starts.
// - Bit holds until next leading edge.
// - Shift register has no address.
// - Transmit enable bit activates transmit mode.
// - Nine-bit select sends nine data bits.
// - Interrupt needs local, peripheral, global enables.
`ifndef SYNC_TX_PARAMS_SVH
`define SYNC_TX_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define OFS_TX_STATUS   8'h00
`define OFS_RX_STATUS   8'h04
`define OFS_BAUD        8'h08
`define OFS_TX_HOLD     8'h0C
`define OFS_IRQ_ENABLE  8'h10
`define OFS_IRQ_FLAG    8'h14
`define OFS_CORE_IRQ    8'h18
`define OFS_PORT_DIR    8'h1C
`define OFS_PIN_LEVEL   8'h20

// ==========================================================
// Field positions
`define BIT_TRANSMIT_INTERRUPT_FLAG        4
`define BIT_TRANSMIT_INTERRUPT_ENABLE        4
`define BIT_GIE         7
`define BIT_PERIPHERAL_INTERRUPT_ENABLE        6
`define BIT_SHIFT_REGISTER_EMPTY_STATUS        1

// ==========================================================
// Reset values and counts
`define RST_BYTE        8'h00
`define RST_PORT_DIR    8'hFF
`define BITS_EIGHT      4'h8
`define BITS_NINE       4'h9
`define BIT_ONE         4'h1

`endif

// >>> hdl/sync_tx_pkg.sv
// Types of the synchronous master transmitter
package sync_tx_pkg;

    typedef struct packed {
        logic clock_source_master_select;
        logic tx9;
        logic transmit_enable_bit;
        logic sync;
        logic rsv;
        logic high_speed_baud_select;
        logic shift_register_empty_status;
        logic ninth_transmit_bit;
    } tx_status_s;

    typedef struct packed {
        logic       serial_port_enable;
        logic       rx9;
        logic       single_receive_enable;
        logic       continuous_receive_enable;
        logic       adden;
        logic [2:0] rsv;
    } rx_status_s;

    typedef enum logic {
        SH_IDLE,
        SH_SHIFT
    } shift_state_e;

endpackage

// >>> hdl/sync_serial_master_transmitter.sv
// Synchronous master transmit path with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "sync_tx_params.svh"

module sync_serial_master_transmitter (
    input  wire logic        CLK,      // 25 MHz system clock
    input  wire logic        RST_N,    // Async reset, low
    input  wire logic        PSEL,     // APB select
    input  wire logic        PENABLE,  // APB access phase
    input  wire logic        PWRITE,   // APB direction
    input  wire logic [7:0]  PADDR,    // APB byte address
    input  wire logic [31:0] PWDATA,   // APB write data
    output logic      [31:0] PRDATA,   // APB read data
    output logic             PREADY,   // APB ready
    output logic             PSLVERR,  // Unmapped address
    input  wire logic        DT_I,     // Data pin level
    output logic             DT_O,     // Data pin drive
    output logic             DT_OE,    // Data pin enable
    input  wire logic        CK_I,     // Clock pin level
    output logic             CK_O,     // Clock pin drive
    output logic             CK_OE,    // Clock pin enable
    output logic             TX_IRQ    // Transmit interrupt
);

    // ======================================================
    // Register state
    sync_tx_pkg::tx_status_s tx_q, tx_d;
    sync_tx_pkg::rx_status_s rx_q, rx_d;
    logic [7:0]  baud_q, baud_d;
    logic [7:0]  ien_q, ien_d;
    logic [7:0]  core_q, core_d;
    logic [7:0]  pdir_q, pdir_d;
    logic [7:0]  hold_q, hold_d;
    logic        hold9_q, hold9_d;
    logic        full_q, full_d;
    logic [31:0] rdata_q, rdata_d;
    logic        err_q, err_d;
    logic [1:0]  pin_m_q, pin_s_q;

    // ======================================================
    // Shifter state
    sync_tx_pkg::shift_state_e st_q, st_d;
    logic [8:0]  tsr_q, tsr_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [9:0]  div_q, div_d;
    logic        ph_q, ph_d;
    logic        ck_q, ck_d;
    logic        dt_q, dt_d;

    logic        setup;
    logic        wr_en;
    logic        hold_wr;
    logic        active;
    logic        master;
    logic        rx_mode;
    logic        tick;
    logic        load;
    logic        transmit_interrupt_flag;
    logic [9:0]  half;

    assign setup   = PSEL & ~PENABLE;
    assign wr_en   = PSEL & PENABLE & PWRITE;
    assign hold_wr = wr_en & (PADDR == `OFS_TX_HOLD);
    assign master  = rx_q.serial_port_enable & tx_q.sync & tx_q.clock_source_master_select;
    assign rx_mode = rx_q.single_receive_enable | rx_q.continuous_receive_enable;
    assign active  = master & ~rx_mode & tx_q.transmit_enable_bit;
    assign transmit_interrupt_flag    = ~full_q;
    // Half shift period, rate is clock over 4 times divisor plus one
    assign half    = {1'b0, baud_q, 1'b1};
    assign tick    = (div_q == 10'h000);
    assign load    = active & full_q
                   & ((st_q == sync_tx_pkg::SH_IDLE)
                   | (tick & ph_q & (cnt_q == `BIT_ONE)));

    // ======================================================
    // Pin synchroniser
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_m_q <= 2'b00;
            pin_s_q <= 2'b00;
        end else begin
            pin_m_q <= {CK_I, DT_I};
            pin_s_q <= pin_m_q;
        end
    end

    // ======================================================
    // Register file next state
    always_comb begin
        tx_d    = tx_q;
        rx_d    = rx_q;
        baud_d  = baud_q;
        ien_d   = ien_q;
        core_d  = core_q;
        pdir_d  = pdir_q;
        hold_d  = hold_q;
        hold9_d = hold9_q;
        full_d  = full_q;
        rdata_d = rdata_q;
        err_d   = err_q;
        if (load) begin
            full_d = 1'b0;
        end
        if (!rx_q.serial_port_enable) begin
            full_d = 1'b0;
        end
        if (setup) begin
            err_d   = 1'b0;
            rdata_d = 32'h0000_0000;
            case (PADDR)
                `OFS_TX_STATUS: begin
                    rdata_d[7:0] = tx_q;
                    rdata_d[`BIT_SHIFT_REGISTER_EMPTY_STATUS] = (st_q == sync_tx_pkg::SH_IDLE);
                end
                `OFS_RX_STATUS:  rdata_d[7:0] = rx_q;
                `OFS_BAUD:       rdata_d[7:0] = baud_q;
                `OFS_TX_HOLD:    rdata_d[7:0] = `RST_BYTE;
                `OFS_IRQ_ENABLE: rdata_d[7:0] = ien_q;
                `OFS_IRQ_FLAG:   rdata_d[`BIT_TRANSMIT_INTERRUPT_FLAG] = transmit_interrupt_flag;
                `OFS_CORE_IRQ:   rdata_d[7:0] = core_q;
                `OFS_PORT_DIR:   rdata_d[7:0] = pdir_q;
                `OFS_PIN_LEVEL:  rdata_d[1:0] = pin_s_q;
                default:         err_d = 1'b1;
            endcase
        end
        if (wr_en) begin
            case (PADDR)
                `OFS_TX_STATUS: begin
                    tx_d      = PWDATA[7:0];
                    tx_d.rsv  = 1'b0;
                    tx_d.shift_register_empty_status = 1'b0;
                end
                `OFS_RX_STATUS: begin
                    rx_d     = PWDATA[7:0];
                    rx_d.rsv = 3'b000;
                end
                `OFS_BAUD:       baud_d = PWDATA[7:0];
                `OFS_IRQ_ENABLE: ien_d  = PWDATA[7:0];
                `OFS_CORE_IRQ:   core_d = PWDATA[7:0];
                `OFS_PORT_DIR:   pdir_d = PWDATA[7:0];
                `OFS_TX_HOLD: begin
                    hold_d  = PWDATA[7:0];
                    hold9_d = tx_q.ninth_transmit_bit;
                    full_d  = rx_q.serial_port_enable;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_q    <= `RST_BYTE;
            rx_q    <= `RST_BYTE;
            baud_q  <= `RST_BYTE;
            ien_q   <= `RST_BYTE;
            core_q  <= `RST_BYTE;
            pdir_q  <= `RST_PORT_DIR;
            hold_q  <= `RST_BYTE;
            hold9_q <= 1'b0;
            full_q  <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            tx_q    <= tx_d;
            rx_q    <= rx_d;
            baud_q  <= baud_d;
            ien_q   <= ien_d;
            core_q  <= core_d;
            pdir_q  <= pdir_d;
            hold_q  <= hold_d;
            hold9_q <= hold9_d;
            full_q  <= full_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // ======================================================
    // Shifter next state
    // shift register never decoded on the bus
    always_comb begin
        st_d  = st_q;
        tsr_d = tsr_q;
        cnt_d = cnt_q;
        div_d = tick ? half : div_q - 10'h001;
        ph_d  = ph_q;
        ck_d  = ck_q;
        dt_d  = dt_q;
        case (st_q)
            sync_tx_pkg::SH_IDLE: begin
                ck_d = 1'b0;
            end
            sync_tx_pkg::SH_SHIFT: begin
                if (tick && !ph_q) begin
                    ck_d = 1'b0;
                    ph_d = 1'b1;
                end else if (tick) begin
                    ph_d = 1'b0;
                    if (cnt_q == `BIT_ONE) begin
                        // no extra clock after last bit
                        st_d = sync_tx_pkg::SH_IDLE;
                        ck_d = 1'b0;
                    end else begin
                        tsr_d = {1'b0, tsr_q[8:1]};
                        dt_d  = tsr_q[1];
                        cnt_d = cnt_q - `BIT_ONE;
                        ck_d  = 1'b1;
                    end
                end
            end
            default: st_d = sync_tx_pkg::SH_IDLE;
        endcase
        if (load) begin
            st_d  = sync_tx_pkg::SH_SHIFT;
            tsr_d = {hold9_q, hold_q};
            dt_d  = hold_q[0];
            cnt_d = tx_q.tx9 ? `BITS_NINE : `BITS_EIGHT;
            ck_d  = 1'b1;
            ph_d  = 1'b0;
            div_d = half;
        end
        if (!active) begin
            st_d = sync_tx_pkg::SH_IDLE;
            ck_d = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q  <= sync_tx_pkg::SH_IDLE;
            tsr_q <= 9'h000;
            cnt_q <= 4'h0;
            div_q <= 10'h000;
            ph_q  <= 1'b0;
            ck_q  <= 1'b0;
            dt_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            tsr_q <= tsr_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            ph_q  <= ph_d;
            ck_q  <= ck_d;
            dt_q  <= dt_d;
        end
    end

    // ======================================================
    // Outputs
    assign PRDATA  = rdata_q;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & err_q;
    // one data line, driven only when transmitting
    // clock driver on in master mode
    assign CK_OE   = master;
    assign CK_O    = ck_q;
    assign DT_OE   = active;
    assign DT_O    = dt_q;
    assign TX_IRQ  = transmit_interrupt_flag & ien_q[`BIT_TRANSMIT_INTERRUPT_ENABLE]
                   & core_q[`BIT_PERIPHERAL_INTERRUPT_ENABLE] & core_q[`BIT_GIE];

    // ======================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_clk_idle_low: assert property (
        (st_q == sync_tx_pkg::SH_IDLE) |-> !CK_O)
        else $error("clock active while idle");

    a_data_leading: assert property (
        $changed(DT_O) && active |-> $rose(CK_O))
        else $error("data moved off leading edge");

    a_flag_clear: assert property (
        hold_wr && rx_q.serial_port_enable |=> !transmit_interrupt_flag)
        else $error("flag not cleared by write");

    // A write in the load cycle refills the holding register at once
    a_load_prompt: assert property (
        active && full_q && (st_q == sync_tx_pkg::SH_IDLE) && !hold_wr
        |=> (st_q == sync_tx_pkg::SH_SHIFT) && !full_q)
        else $error("idle shifter did not load");

    a_nine_bits: assert property (
        load && tx_q.tx9 |=> cnt_q == `BITS_NINE)
        else $error("nine-bit count wrong");

    a_rx_no_drive: assert property (
        rx_mode |-> !DT_OE)
        else $error("data driven in receive mode");

    a_port_off: assert property (
        !rx_q.serial_port_enable |-> (!CK_OE && !DT_OE) ##1 (st_q == sync_tx_pkg::SH_IDLE))
        else $error("port active while disabled");

    a_busy_status: assert property (
        load |=> ##1 (st_q == sync_tx_pkg::SH_SHIFT) || !active)
        else $error("shifter left early");

    a_irq_gate: assert property (
        TX_IRQ |-> core_q[`BIT_GIE] && !full_q)
        else $error("interrupt without enable");

    a_ck_master: assert property (
        rx_q.serial_port_enable && tx_q.sync && tx_q.clock_source_master_select |-> CK_OE)
        else $error("clock driver off in master");

    a_data_hold: assert property (
        !$rose(CK_O) |-> $stable(DT_O))
        else $error("data moved without leading edge");

    a_no_start_bit: assert property (
        load |=> CK_O && (DT_O == $past(hold_q[0])))
        else $error("first bit is not data bit zero");

    a_last_bit: assert property (
        (st_q == sync_tx_pkg::SH_SHIFT) && tick && ph_q && (cnt_q == `BIT_ONE) && !full_q
        |=> (st_q == sync_tx_pkg::SH_IDLE) && !CK_O)
        else $error("clock ran past last bit");

    // Holding data must not be taken in the middle of a bit
    a_hold_waits: assert property (
        full_q && rx_q.serial_port_enable && (st_q == sync_tx_pkg::SH_SHIFT) && !tick |=> full_q)
        else $error("holding register taken mid character");

    a_serial_port_enable_write: assert property (
        hold_wr && !rx_q.serial_port_enable |=> !full_q)
        else $error("write accepted while port off");

endmodule // sync_serial_master_transmitter

`default_nettype wire

// >>> bench/sync_slave_model.sv
// Behavioural slave that captures bits from the shared serial lines
`timescale 1ns/1ps
`default_nettype none

module sync_slave_model (
    input  wire logic        ck,       // Shared clock line
    input  wire logic        dt,       // Shared data line
    input  wire logic        clr,      // Restart capture
    output logic      [17:0] rx_bits,  // Newest bit at the top
    output logic      [4:0]  rx_count  // Bits taken so far
);
    // ==========================================================
    // Capture
    // shift on trailing edge
    always @(negedge ck or posedge clr) begin
        if (clr) begin
            rx_bits  <= 18'h0_0000;
            rx_count <= 5'h00;
        end else begin
            rx_bits  <= {dt, rx_bits[17:1]};
            rx_count <= rx_count + 5'h01;
        end
    end
endmodule // sync_slave_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the synchronous master transmitter
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int HALF  = 4;      // Half period at divisor 1
    localparam int LIMIT = 20000;  // Cycle ceiling of the run
    logic        clk, rst_n, psel, penable, pwrite, clr, err, ck_p, dt_p;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, dt_o, dt_oe, ck_o, ck_oe, tx_irq;
    logic [17:0] rx_bits;
    logic [4:0]  rx_count;
    int          failures, checks_done, hi_cnt, cycles;
    // Released lines: data pulled high, clock pulled low
    wire         dt_wire = dt_oe ? dt_o : 1'b1;
    wire         ck_wire = ck_oe ? ck_o : 1'b0;

    sync_serial_master_transmitter sync_serial_master_transmitter_inst (
        .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .DT_I(dt_wire), .DT_O(dt_o), .DT_OE(dt_oe), .CK_I(ck_wire), .CK_O(ck_o),
        .CK_OE(ck_oe), .TX_IRQ(tx_irq));
    sync_slave_model sync_slave_model_inst (
        .ck(ck_wire), .dt(dt_wire), .clr(clr), .rx_bits(rx_bits), .rx_count(rx_count));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h00_0000, e});
    endtask

    // Clock-high count restarts with the slave, before the first holding write
    task automatic clr_slave;
        clr = 1'b1;
        hi_cnt = 0;
        #1 clr = 1'b0;
    endtask

    // Waits for the slave to take nbits, then judges bits and clock count
    task automatic xfer(input logic [17:0] exp, input int nbits);
        for (int i = 0; i < 2000 && rx_count != nbits; i++) @(posedge clk);
        repeat (8) @(posedge clk);
        chk(rx_count, nbits);
        chk(rx_bits >> (18 - nbits), exp);
        chk(hi_cnt, nbits * HALF);
    endtask

    task print_verdict;
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task test_reset;
        rchk(8'h00, 8'h02);
        rchk(8'h04, 8'h00);
        rchk(8'h08, 8'h00);
        rchk(8'h10, 8'h00);
        rchk(8'h18, 8'h00);
        rchk(8'h1C, 8'hFF);
        rchk(8'h0C, 8'h00);
        rchk(8'h14, 8'h10);
        rchk(8'h20, 8'h01);
        chk(err, 1'b0);
        rchk(8'h24, 8'h00);
        chk(err, 1'b1);
        $display("test_reset done");
    endtask

    task test_char8;
        wr(8'h08, 8'h01);
        wr(8'h04, 8'h80);
        wr(8'h00, 8'hB0);
        chk(ck_oe, 1'b1);
        chk(dt_oe, 1'b1);
        rchk(8'h04, 8'h80);
        rchk(8'h20, 8'h00);
        clr_slave;
        wr(8'h0C, 8'hA5);
        @(posedge clk);
        #1;
        chk(ck_o, 1'b1);
        rchk(8'h00, 8'hB0);
        xfer(18'h0_00A5, 8);
        rchk(8'h00, 8'hB2);
        $display("test_char8 done");
    endtask

    task test_back2back;
        wr(8'h10, 8'h10);
        wr(8'h18, 8'hC0);
        clr_slave;
        wr(8'h0C, 8'h3C);
        wr(8'h0C, 8'hC3);
        rchk(8'h14, 8'h00);
        chk(tx_irq, 1'b0);
        xfer(18'h0_C33C, 16);
        rchk(8'h14, 8'h10);
        chk(tx_irq, 1'b1);
        $display("test_back2back done");
    endtask

    task test_irq;
        for (int k = 0; k < 8; k++) begin
            wr(8'h10, {3'h0, k[0], 4'h0});
            wr(8'h18, {k[2], k[1], 6'h00});
            chk(tx_irq, k == 7);
        end
        $display("test_irq done");
    endtask

    task test_nine;
        wr(8'h00, 8'hF1);
        clr_slave;
        wr(8'h0C, 8'h5A);
        xfer(18'h0_015A, 9);
        $display("test_nine done");
    endtask

    task test_receive;
        wr(8'h04, 8'hA0);
        chk(dt_oe, 1'b0);
        chk(ck_oe, 1'b1);
        clr_slave;
        wr(8'h0C, 8'h81);
        repeat (40) @(posedge clk);
        chk(rx_count, 5'h00);
        wr(8'h04, 8'h00);
        chk(ck_oe, 1'b0);
        chk(dt_oe, 1'b0);
        wr(8'h0C, 8'h42);
        rchk(8'h14, 8'h10);
        $display("test_receive done");
    endtask

    // ==========================================================
    // Line monitor and run control
    always @(negedge clk) begin
        // data moves only as the clock rises
        if (dt_oe === 1'b1 && !(ck_p === 1'b0 && ck_o === 1'b1)) chk(dt_o, dt_p);
        ck_p = ck_o;
        dt_p = dt_o;
        if (ck_o === 1'b1) hi_cnt++;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            print_verdict;
        end
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        {rst_n, psel, penable, pwrite, clr} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        test_reset;
        test_char8;
        test_back2back;
        test_irq;
        test_nine;
        test_receive;
        print_verdict;
    end
endmodule // tb
`default_nettype wire
